// ==== design/mlsu_top.sv ====
// Limit comparison and interrupt status flags of a thermal monitor,
// reached over an AHB-Lite slave. Measurement results and fan, diode
// and overtemperature conditions come from logic on the same clock.
//
// What this block does
// RULE1 - Status one bit 1 flags core rail limit, bit 2 supply rail limit.
// RULE2 - Status one bits 4,5,6 flag remote one, local, remote two temps.
// RULE3 - Voltage and temperature flags clear on read only if the fault ended.
// RULE4 - Status one bit 7 is the OR of all status two bits.
// RULE5 - Status two bit 1 flags overtemp; clears on read after hysteresis release.
// RULE6 - Status two bits 2..4 flag slow fans, suppressed while drive is off.
// RULE7 - Status two bit 5 flags slow fan four, suppressed while third drive off.
// RULE8 - In GPIO mode status two bit 5 is writable and drives the pin.
// RULE9 - In timer mode bit 5 sets when assertion time exceeds timer limit.
// RULE10 - Status two bits 6 and 7 flag faults on diode inputs one and two.
// RULE11 - Status two bit 0 reserved, or remote two latch on latching variant.
// RULE12 - Limit registers stay writable regardless of any configuration lock.
// RULE13 - A temperature passing a limit by one degree sets its flag.
// RULE14 - Temperature low limits reset to 0x01, high limits to 0xff.
// RULE15 - High violation when reading above limit; low when at or below.
// RULE16 - Compare after each new measurement; set flags hold until a clearing read.
// RULE17 - Status registers reset to zero; voltage limits reset 0x00 and 0xff.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mlsu_top #(
  parameter int ADDR_W = 10,
  parameter bit LATCH_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Measurement results
  input wire logic meas_valid,
  input wire mlsu_pkg::mlsu_meas_t meas,
  // Fan, diode and overtemperature conditions
  input wire mlsu_pkg::mlsu_events_t events,
  input wire logic [7:0] timer_assert_time,
  // Shared pin and interrupt
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic irq
);
  import mlsu_pkg::*;

  // Decode needs the full ten-bit window; no bus is wider than 32 bits
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
    $error("mlsu_top: ADDR_W must be 10 to 32");
  end
  if (NLIM != 2 * NCH) begin : g_bad_lim
    $error("mlsu_top: limit table needs a low and a high limit per channel");
  end

  mlsu_bus_state_t state_reg;
  logic [7:0] dp_idx_reg;
  logic dp_ok_reg;
  logic [7:0] lim_reg [NLIM];
  logic [7:0] status_first_reg;
  logic [7:0] status_second_reg;
  logic [NCH-1:0] viol_reg;
  logic [1:0] pin_mode_reg;
  logic [7:0] timer_limit_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] reading [NCH];
  logic [NCH-1:0] viol_now;
  logic addr_take;
  logic addr_ok;
  logic addr_high_zero;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] set_first;
  logic [7:0] hold_first;
  logic [7:0] set_second;
  logic [7:0] hold_second;
  logic [7:0] status_first_next;
  logic [7:0] status_second_next;
  logic [1:0] irq_status_next;
  logic [7:0] read_value;

  // Bus address decode
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_ok = (haddr[1:0] == 2'h0) && addr_high_zero;
  assign wr_en = (state_reg == MLSU_WRITE) && dp_ok_reg;
  assign rd_en = (state_reg == MLSU_READ) && dp_ok_reg;
  assign wdata = hwdata[7:0];

  // Address bits above the register window must be zero
  if (ADDR_W > 10) begin : g_addr_high
    assign addr_high_zero = (haddr[ADDR_W-1:10] == '0);
  end else begin : g_addr_flat
    assign addr_high_zero = 1'b1;
  end

  // Writes finish without wait; reads take one wait state so that a read
  // right after a write to the same register sees the new value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= MLSU_IDLE;
      hreadyout <= 1'b1;
    end else begin
      case (state_reg)
        MLSU_READ: begin
          state_reg <= MLSU_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          if (addr_take) begin
            state_reg <= hwrite ? MLSU_WRITE : MLSU_READ;
            hreadyout <= hwrite;
          end else begin
            state_reg <= MLSU_IDLE;
            hreadyout <= 1'b1;
          end
        end
      endcase
    end
  end

  // Address phase capture for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_idx_reg <= 8'h00;
      dp_ok_reg <= 1'b0;
    end else if (addr_take && state_reg != MLSU_READ) begin
      dp_idx_reg <= haddr[9:2];
      dp_ok_reg <= addr_ok;
    end
  end

  // Only OKAY answers; unmapped addresses read zero and ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Limit registers, one per generate entry; no lock gates them
  for (genvar i = 0; i < NLIM; i++) begin : g_lim
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lim_reg[i] <= LIM_RST[i]; // RULE14 RULE17
      end else if (wr_en && dp_idx_reg == LIM_IDX[i]) begin
        lim_reg[i] <= wdata; // RULE12
      end
    end
  end

  // Limit comparison per channel
  assign reading[0] = meas.core_volt;
  assign reading[1] = meas.supply_volt;
  assign reading[2] = meas.remote_one_temp;
  assign reading[3] = meas.local_temp;
  assign reading[4] = meas.remote_two_temp;

  for (genvar c = 0; c < NCH; c++) begin : g_cmp
    // Strictly above high, or at or below low; one degree past either trips
    assign viol_now[c] = (reading[c] > lim_reg[2*c+1]) || (reading[c] <= lim_reg[2*c]); // RULE15 RULE13
  end

  // Condition of the latest measurement decides whether a read may clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      viol_reg <= '0;
    end else if (meas_valid) begin
      viol_reg <= viol_now; // RULE16
    end
  end

  // First status register: set and hold masks by bit position
  always_comb begin
    set_first = 8'h00;
    hold_first = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      set_first[ST1_BIT[c]] = meas_valid && viol_now[c]; // RULE1 RULE2 RULE16
      hold_first[ST1_BIT[c]] = meas_valid ? viol_now[c] : viol_reg[c];
    end
  end

  // A read clears only bits whose cause has gone; a new set wins
  always_comb begin
    status_first_next = status_first_reg;
    if (rd_en && dp_idx_reg == IDX_STATUS_FIRST) begin
      status_first_next = status_first_reg & hold_first; // RULE3
    end
    status_first_next = status_first_next | set_first;
    status_first_next[ST1_SUMMARY] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_first_reg <= STATUS_RST; // RULE17
    end else begin
      status_first_reg <= status_first_next;
    end
  end

  // Second status register conditions, sampled every cycle
  always_comb begin
    set_second = 8'h00;
    hold_second = 8'h00;
    // Latch bit exists only on the latching variant
    set_second[ST2_LATCH] = LATCH_VARIANT && events.remote_two_latch; // RULE11
    hold_second[ST2_LATCH] = LATCH_VARIANT && events.remote_two_latch;
    set_second[ST2_OVERTEMP] = events.overtemp_over; // RULE5
    hold_second[ST2_OVERTEMP] = !events.overtemp_released; // RULE5
    for (int f = 0; f < 3; f++) begin
      set_second[ST2_FAN_FIRST+f] = events.fan_slow[f] && events.fan_drive_on[f]; // RULE6
      hold_second[ST2_FAN_FIRST+f] = events.fan_slow[f] && events.fan_drive_on[f];
    end
    case (pin_mode_reg)
      PIN_FAN_TACH: begin
        set_second[ST2_SHARED] = events.fourth_fan_slow && events.fan_drive_on[2]; // RULE7
        hold_second[ST2_SHARED] = events.fourth_fan_slow && events.fan_drive_on[2];
      end
      PIN_TIMER_IN: begin
        set_second[ST2_SHARED] = timer_assert_time > timer_limit_reg; // RULE9
        hold_second[ST2_SHARED] = timer_assert_time > timer_limit_reg;
      end
      default: begin
        set_second[ST2_SHARED] = 1'b0;
        hold_second[ST2_SHARED] = 1'b0;
      end
    endcase
    for (int d = 0; d < 2; d++) begin
      set_second[ST2_DIODE_FIRST+d] = events.diode_fault[d]; // RULE10
      hold_second[ST2_DIODE_FIRST+d] = events.diode_fault[d];
    end
  end

  always_comb begin
    status_second_next = status_second_reg;
    if (rd_en && dp_idx_reg == IDX_STATUS_SECOND) begin
      status_second_next = status_second_reg & hold_second; // RULE5 RULE16
    end
    status_second_next = status_second_next | set_second;
    if (pin_mode_reg == PIN_GPIO_OUT) begin
      // Bit is plain storage here: no clear on read, no hardware set
      status_second_next[ST2_SHARED] = status_second_reg[ST2_SHARED];
      if (wr_en && dp_idx_reg == IDX_STATUS_SECOND) begin
        status_second_next[ST2_SHARED] = wdata[ST2_SHARED]; // RULE8
      end
    end
    if (!LATCH_VARIANT) begin
      status_second_next[ST2_LATCH] = 1'b0; // RULE11
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_second_reg <= STATUS_RST; // RULE17
    end else begin
      status_second_reg <= status_second_next;
    end
  end

  // Shared pin mode; mode 3 leaves the shared bit unused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_mode_reg <= PIN_FAN_TACH;
    end else if (wr_en && dp_idx_reg == IDX_PIN_MODE) begin
      pin_mode_reg <= wdata[1:0];
    end
  end

  // Timer limit, compared against the measured assertion time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_limit_reg <= TIMER_LIMIT_RST;
    end else if (wr_en && dp_idx_reg == IDX_TIMER_LIMIT) begin
      timer_limit_reg <= wdata;
    end
  end

  // Pin level follows the next value, so it changes on the write edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_pin_out <= 1'b0;
    end else begin
      shared_pin_out <= status_second_next[ST2_SHARED]; // RULE8
    end
  end

  // Drive the shared pin only while it is a general-purpose output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_pin_oe <= 1'b0;
    end else begin
      shared_pin_oe <= (pin_mode_reg == PIN_GPIO_OUT); // RULE8
    end
  end

  // Interrupt: bit 0 for a fresh flag in status one, bit 1 for status two.
  // Write one clears; a new event in the same cycle wins.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_en && dp_idx_reg == IDX_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~wdata[1:0];
    end
    irq_status_next[0] = irq_status_next[0] || (|(set_first & ~status_first_reg));
    irq_status_next[1] = irq_status_next[1] || (|(status_second_next & ~status_second_reg));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= IRQ_RST;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= IRQ_RST;
    end else if (wr_en && dp_idx_reg == IDX_IRQ_MASK) begin
      irq_mask_reg <= wdata[1:0];
    end
  end

  // Registered so the pin cannot glitch; changes on the same edge as the status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Read mux; the summary bit is formed here so it never lags status two
  always_comb begin
    read_value = 8'h00;
    if (dp_ok_reg) begin
      case (dp_idx_reg)
        IDX_STATUS_FIRST: begin
          read_value = status_first_reg;
          read_value[ST1_SUMMARY] = |status_second_reg; // RULE4
        end
        IDX_STATUS_SECOND: read_value = status_second_reg;
        IDX_PIN_MODE: read_value = {6'h00, pin_mode_reg};
        IDX_IRQ_STATUS: read_value = {6'h00, irq_status_reg};
        IDX_IRQ_MASK: read_value = {6'h00, irq_mask_reg};
        IDX_TIMER_LIMIT: read_value = timer_limit_reg;
        default: begin
          for (int i = 0; i < NLIM; i++) begin
            if (dp_idx_reg == LIM_IDX[i]) begin
              read_value = lim_reg[i];
            end
          end
        end
      endcase
    end
  end

  // Loaded at the end of the wait state, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state_reg == MLSU_READ) begin
      hrdata <= {24'h00_0000, read_value};
    end
  end

endmodule : mlsu_top

`default_nettype wire

// ==== design/mlsu_pkg.sv ====
// Package for the monitor limit and status unit: register indices,
// reset values, bit positions and the measurement carrier.
// Assumes a 32-bit AHB-Lite register bus with byte address = 4 * index.
package mlsu_pkg;

  localparam int NCH = 5;
  localparam int NLIM = 10;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS_FIRST = 8'h41;
  localparam logic [7:0] IDX_STATUS_SECOND = 8'h42;
  localparam logic [7:0] IDX_PIN_MODE = 8'h60;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h61;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
  localparam logic [7:0] IDX_TIMER_LIMIT = 8'h7a;

  // Limit table: entry 2*ch is the low limit, 2*ch+1 the high limit
  // Channels: core rail, supply rail, remote one, local, remote two
  localparam logic [7:0] LIM_IDX [NLIM] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4e,
                                            8'h4f, 8'h50, 8'h51, 8'h52, 8'h53};
  localparam logic [7:0] LIM_RST [NLIM] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h01,
                                            8'hff, 8'h01, 8'hff, 8'h01, 8'hff};

  // Status bit of the first register for each channel
  localparam int ST1_BIT [NCH] = '{1, 2, 4, 5, 6};
  localparam int ST1_SUMMARY = 7;

  // Second status register layout
  localparam int ST2_LATCH = 0;
  localparam int ST2_OVERTEMP = 1;
  localparam int ST2_FAN_FIRST = 2;
  localparam int ST2_SHARED = 5;
  localparam int ST2_DIODE_FIRST = 6;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] TIMER_LIMIT_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Shared pin modes
  localparam logic [1:0] PIN_FAN_TACH = 2'h0;
  localparam logic [1:0] PIN_GPIO_OUT = 2'h1;
  localparam logic [1:0] PIN_TIMER_IN = 2'h2;

  typedef struct packed {
    logic [7:0] core_volt;
    logic [7:0] supply_volt;
    logic [7:0] remote_one_temp;
    logic [7:0] local_temp;
    logic [7:0] remote_two_temp;
  } mlsu_meas_t;

  typedef struct packed {
    logic overtemp_over;
    logic overtemp_released;
    logic [2:0] fan_slow;
    logic fourth_fan_slow;
    logic [2:0] fan_drive_on;
    logic [1:0] diode_fault;
    logic remote_two_latch;
  } mlsu_events_t;

  typedef enum logic [1:0] {
    MLSU_IDLE,
    MLSU_WRITE,
    MLSU_READ
  } mlsu_bus_state_t;

endpackage : mlsu_pkg

// ==== bench/mlsu_monitor.sv ====
// Checker for mlsu_top: bus timing and read values.
// Assumes one bus master with hready looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module mlsu_monitor #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Shared pin
  input wire logic shared_pin_oe
);
  import mlsu_pkg::*;
  logic take;
  assign take = hsel && htrans[1] && hready;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  data_stable_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (take && !hwrite && haddr[9:2] == 8'h00 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  first_gaps_a: assert property (take && !hwrite && haddr[9:2] == IDX_STATUS_FIRST
    |-> ##2 (hrdata[0] == 1'b0 && hrdata[3] == 1'b0))
    else $error("unused status bits set");
  pin_enable_a: assert property (take && hwrite && haddr[9:2] == IDX_PIN_MODE
    ##1 hwdata[1:0] == PIN_GPIO_OUT |-> ##[1:2] shared_pin_oe)
    else $error("pin enable late");
  cover property (take && !hwrite);
  cover property (take && hwrite);
  cover property ($rose(shared_pin_oe));
endmodule : mlsu_monitor
bind mlsu_top mlsu_monitor #(.ADDR_W(ADDR_W)) u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .shared_pin_oe(shared_pin_oe));
`default_nettype wire

// ==== bench/monitor_limit_status_unit_tb.sv ====
// Testbench for mlsu_top: bus tasks and register check sequences.
// Assumes hready looped back from hreadyout, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module monitor_limit_status_unit_tb;
  import mlsu_pkg::*;
  localparam mlsu_events_t IDLE = '{overtemp_released: 1'b1, fan_drive_on: 3'h7, default: '0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [9:0] haddr = 10'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [31:0] hrdata_l;
  logic hreadyout_l;
  logic hresp;
  logic shared_pin_out;
  logic shared_pin_oe;
  logic irq;
  logic meas_valid = 1'b0;
  mlsu_meas_t meas = '0;
  mlsu_events_t events = IDLE;
  logic [7:0] timer_assert_time = 8'h0;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] q;
  logic [31:0] q_l;
  logic [7:0] b;
  mlsu_events_t e;
  logic [7:0] vals [4] = '{8'h80, 8'h81, 8'h21, 8'h20};
  always #2 hclk = ~hclk;
  mlsu_top #(.ADDR_W(10), .LATCH_VARIANT(1'b0)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid), .meas(meas), .events(events),
    .timer_assert_time(timer_assert_time), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .irq(irq));
  // Latching variant on the same bus; answers in lock step with dut
  mlsu_top #(.ADDR_W(10), .LATCH_VARIANT(1'b1)) dut_latch (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_l), .hrdata(hrdata_l),
    .hreadyout(hreadyout_l), .hresp(), .meas_valid(meas_valid), .meas(meas), .events(events),
    .timer_assert_time(timer_assert_time), .shared_pin_out(), .shared_pin_oe(), .irq());
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] id, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error item %h expected %h seen %h", id, exp, got);
      n_errors++;
    end
  endtask : chk
  // Bounded wait for hready high at a rising edge
  task automatic rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : rdy
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    q_l = hrdata_l;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(idx, {24'h0, exp}, q);
  endtask : rd
  // Channel ch gets v, the others an in-range reading
  task automatic put_meas(input int ch, input logic [7:0] v);
    logic [39:0] m;
    m = {5{8'h50}};
    if (ch >= 0) m[8*(4-ch) +: 8] = v;
    @(posedge hclk);
    meas <= m;
    meas_valid <= 1'b1;
    @(posedge hclk);
    meas_valid <= 1'b0;
  endtask : put_meas
  task automatic put_ev(input mlsu_events_t ev);
    @(posedge hclk);
    events <= ev;
    @(posedge hclk);
    events <= IDLE;
  endtask : put_ev
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < NLIM; i++) rd(LIM_IDX[i], LIM_RST[i]);
    rd(IDX_STATUS_FIRST, STATUS_RST);
    rd(IDX_STATUS_SECOND, STATUS_RST);
    rd(8'h00, 8'h00);
    wr(IDX_STATUS_FIRST, 8'hff);
    rd(IDX_STATUS_FIRST, 8'h00);
    for (int i = 0; i < NLIM; i++) wr(LIM_IDX[i], i[0] ? 8'h80 : 8'h20);
    for (int i = 0; i < NLIM; i++) rd(LIM_IDX[i], i[0] ? 8'h80 : 8'h20);
    // At the high limit no flag, one step past must; at the low limit the flag must set
    for (int ch = 0; ch < NCH; ch++) begin
      for (int k = 0; k < 4; k++) begin
        b = k[0] ? 8'h1 << ST1_BIT[ch] : 8'h00;
        put_meas(ch, vals[k]);
        rd(IDX_STATUS_FIRST, b);
        rd(IDX_STATUS_FIRST, b);
        put_meas(-1, 8'h00);
        rd(IDX_STATUS_FIRST, b);
        rd(IDX_STATUS_FIRST, 8'h00);
      end
    end
    wr(IDX_IRQ_STATUS, 8'h03);
    put_meas(3, 8'hff);
    repeat (2) @(posedge hclk);
    chk(8'hee, 32'h0, {31'h0, irq});
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge hclk);
    chk(8'hee, 32'h1, {31'h0, irq});
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge hclk);
    chk(8'hee, 32'h0, {31'h0, irq});
    put_meas(-1, 8'h00);
    rd(IDX_STATUS_FIRST, 8'h20);
    for (int k = 0; k < 8; k++) begin
      e = IDLE;
      if (k == 0) e.remote_two_latch = 1'b1;
      if (k == 1) e.overtemp_over = 1'b1;
      if (k inside {[2:4]}) e.fan_slow[k-2] = 1'b1;
      if (k == 5) e.fourth_fan_slow = 1'b1;
      if (k > 5) e.diode_fault[k-6] = 1'b1;
      b = (k == 0) ? 8'h00 : 8'h1 << k;
      put_ev(e);
      rd(IDX_STATUS_FIRST, (b != 8'h00) ? 8'h80 : 8'h00);
      rd(IDX_STATUS_SECOND, b);
      chk(IDX_STATUS_SECOND, {24'h0, (k == 0) ? 8'h01 : b}, q_l);
      rd(IDX_STATUS_SECOND, 8'h00);
      chk(IDX_STATUS_SECOND, 32'h0, q_l);
    end
    // Overtemp stays until the hysteresis release
    e = IDLE;
    e.overtemp_released = 1'b0;
    e.overtemp_over = 1'b1;
    @(posedge hclk);
    events <= e;
    e.overtemp_over = 1'b0;
    @(posedge hclk);
    events <= e;
    rd(IDX_STATUS_SECOND, 8'h02);
    events <= IDLE;
    rd(IDX_STATUS_SECOND, 8'h02);
    rd(IDX_STATUS_SECOND, 8'h00);
    for (int k = 0; k < 4; k++) begin
      e = IDLE;
      e.fan_drive_on[(k > 2) ? 2 : k] = 1'b0;
      if (k < 3) e.fan_slow[k] = 1'b1;
      else e.fourth_fan_slow = 1'b1;
      put_ev(e);
      rd(IDX_STATUS_SECOND, 8'h00);
    end
    wr(IDX_PIN_MODE, {6'h0, PIN_GPIO_OUT});
    wr(IDX_STATUS_SECOND, 8'h20);
    @(posedge hclk);
    chk(8'hf0, 32'h3, {30'h0, shared_pin_oe, shared_pin_out});
    rd(IDX_STATUS_SECOND, 8'h20);
    wr(IDX_STATUS_SECOND, 8'h00);
    @(posedge hclk);
    chk(8'hf0, 32'h2, {30'h0, shared_pin_oe, shared_pin_out});
    // Unused pin mode: shared bit never set, pin not driven
    wr(IDX_PIN_MODE, 8'h03);
    e = IDLE;
    e.fourth_fan_slow = 1'b1;
    put_ev(e);
    rd(IDX_STATUS_SECOND, 8'h00);
    chk(8'hf0, 32'h0, {31'h0, shared_pin_oe});
    wr(IDX_PIN_MODE, {6'h0, PIN_TIMER_IN});
    wr(IDX_TIMER_LIMIT, 8'h10);
    timer_assert_time <= 8'h10;
    rd(IDX_STATUS_SECOND, 8'h00);
    timer_assert_time <= 8'h11;
    @(posedge hclk);
    timer_assert_time <= 8'h00;
    rd(IDX_STATUS_SECOND, 8'h20);
    rd(IDX_STATUS_SECOND, 8'h00);
    print_verdict();
  end
endmodule : monitor_limit_status_unit_tb
`default_nettype wire
